// ### rtl/pix_interrupt_expander.sv
// Peripheral interrupt expander: 96 member lines in 12 groups onto 12 CPU inputs.
// Assumes peripherals, CPU and bus all run on i_clk.
//
// What this block does
// - Eight lines per CPU input, twelve groups
// - Forty-five wired; groups 4, 5, 7, 12 empty
// - Trap n fetches vector of member n.1
// - Group one: sequencers, external, converter, timer, wake
// - Group two: pwm trip one to eight
// - Group three: pwm event one to eight
// - Group six: serial port receive, transmit
// - Group eight: two-wire interrupts one, two
// - Reserved member set by software acts interrupt
// - Flag write overwrites whole group; a line rising in that cycle still sets its flag
// - Control, ack, enable/flag pairs at indices
// - Groups nine to eleven: uart, pwm nine-sixteen
// - Control registers need no write unlock
// - Vector table 256 words, unlock protected
`timescale 1ns/100ps
`default_nettype none

module pix_interrupt_expander (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire pix_pkg::pix_periph_irq_t i_periph,
    input wire logic i_protected_write_unlock,
    input wire pix_pkg::pix_vec_req_t i_vec_req,
    output logic [11:0] o_cpu_irq,
    output pix_pkg::pix_vec_rsp_t o_vec_rsp,
    input wire logic [15:0] i_axi_awaddr,
    input wire logic i_axi_awvalid,
    output logic o_axi_awready,
    input wire logic [31:0] i_axi_wdata,
    input wire logic [3:0] i_axi_wstrb,
    input wire logic i_axi_wvalid,
    output logic o_axi_wready,
    output logic [1:0] o_axi_bresp,
    output logic o_axi_bvalid,
    input wire logic i_axi_bready,
    input wire logic [15:0] i_axi_araddr,
    input wire logic i_axi_arvalid,
    output logic o_axi_arready,
    output logic [31:0] o_axi_rdata,
    output logic [1:0] o_axi_rresp,
    output logic o_axi_rvalid,
    input wire logic i_axi_rready
);
    import pix_pkg::*;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [15:0] pix_merge(input logic [15:0] old_v,
                                              input logic [15:0] new_v,
                                              input logic [1:0] strb);
        logic [15:0] mask;
        mask = {{8{strb[1]}}, {8{strb[0]}}};
        return (old_v & ~mask) | (new_v & mask);
    endfunction : pix_merge

    function automatic logic [2:0] pix_lowest(input logic [7:0] v);
        logic [2:0] p;
        p = 3'h0;
        for (int i = 7; i >= 0; i--)
        begin
            if (v[i])
            begin
                p = 3'(i);
            end
        end
        return p;
    endfunction : pix_lowest

    // ------------------------------------------------------------
    // Peripheral line map
    // ------------------------------------------------------------
    logic [GROUP_SIZE-1:0] line_w [NUM_GROUPS];

    always_comb
    begin
        for (int g = 0; g < NUM_GROUPS; g++)
        begin
            line_w[g] = '0;
        end
        line_w[0] = {i_periph.low_power_wake_irq, i_periph.timer_zero_irq,
                     i_periph.converter_irq, i_periph.ext_irq_two, i_periph.ext_irq_one,
                     1'b0, i_periph.sequencer_two_irq, i_periph.sequencer_one_irq};
        line_w[1] = i_periph.pwm_trip_irq[7:0];
        line_w[2] = i_periph.pwm_event_irq[7:0];
        line_w[5] = {6'h00, i_periph.serial_port_tx_irq, i_periph.serial_port_rx_irq};
        line_w[7] = {6'h00, i_periph.two_wire_irq_two, i_periph.two_wire_irq_one};
        line_w[8] = {6'h00, i_periph.uart_tx_irq, i_periph.uart_rx_irq};
        line_w[9] = i_periph.pwm_trip_irq[15:8];
        line_w[10] = i_periph.pwm_event_irq[15:8];
        // groups 4, 5, 7, 12 stay low
    end

    // ------------------------------------------------------------
    // Bus write channel
    // ------------------------------------------------------------
    logic aw_hold_r, aw_hold_nxt;
    logic [13:0] aw_idx_r, aw_idx_nxt;
    logic w_hold_r, w_hold_nxt;
    logic [15:0] w_data_r, w_data_nxt;
    logic [1:0] w_strb_r, w_strb_nxt;
    logic awready_r, awready_nxt;
    logic wready_r, wready_nxt;
    logic bvalid_r, bvalid_nxt;
    logic [1:0] bresp_r, bresp_nxt;
    logic wr_fire;

    // One write at a time; AW and W in either order
    assign wr_fire = aw_hold_r && w_hold_r && !bvalid_r;

    always_comb
    begin
        aw_hold_nxt = aw_hold_r;
        aw_idx_nxt = aw_idx_r;
        w_hold_nxt = w_hold_r;
        w_data_nxt = w_data_r;
        w_strb_nxt = w_strb_r;
        bvalid_nxt = bvalid_r;
        bresp_nxt = bresp_r;
        if (awready_r && i_axi_awvalid)
        begin
            aw_hold_nxt = 1'b1;
            aw_idx_nxt = i_axi_awaddr[15:2];
        end
        if (wready_r && i_axi_wvalid)
        begin
            w_hold_nxt = 1'b1;
            w_data_nxt = i_axi_wdata[15:0];
            w_strb_nxt = i_axi_wstrb[1:0];
        end
        if (bvalid_r && i_axi_bready)
        begin
            bvalid_nxt = 1'b0;
        end
        if (wr_fire)
        begin
            aw_hold_nxt = 1'b0;
            w_hold_nxt = 1'b0;
            bvalid_nxt = 1'b1;
            bresp_nxt = (aw_idx_r >= IDX_CTRL && aw_idx_r <= IDX_VEC_LAST) ?
                        RESP_OKAY : RESP_SLVERR;
        end
        awready_nxt = !aw_hold_nxt && !bvalid_nxt;
        wready_nxt = !w_hold_nxt && !bvalid_nxt;
    end

    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            aw_hold_r <= 1'b0;
            aw_idx_r <= '0;
            w_hold_r <= 1'b0;
            w_data_r <= '0;
            w_strb_r <= '0;
            awready_r <= 1'b0;
            wready_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
        end
        else
        begin
            aw_hold_r <= aw_hold_nxt;
            aw_idx_r <= aw_idx_nxt;
            w_hold_r <= w_hold_nxt;
            w_data_r <= w_data_nxt;
            w_strb_r <= w_strb_nxt;
            awready_r <= awready_nxt;
            wready_r <= wready_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
        end
    end

    // ------------------------------------------------------------
    // Vector table
    // ------------------------------------------------------------
    // Not reset: contents are software's job after power-up
    logic [15:0] vec_mem [VEC_WORDS];
    logic vec_wr;

    assign vec_wr = wr_fire && i_protected_write_unlock &&
                    aw_idx_r >= IDX_VEC_FIRST && aw_idx_r <= IDX_VEC_LAST;

    always_ff @(posedge i_clk)
    begin
        if (vec_wr)
        begin
            vec_mem[aw_idx_r[7:0]] <= pix_merge(vec_mem[aw_idx_r[7:0]], w_data_r, w_strb_r);
        end
    end

    // ------------------------------------------------------------
    // Group enable and flag registers
    // ------------------------------------------------------------
    logic [GROUP_SIZE-1:0] flag_w [NUM_GROUPS];
    logic [GROUP_SIZE-1:0] enable_w [NUM_GROUPS];
    logic [GROUP_SIZE-1:0] pend_nxt_w [NUM_GROUPS];
    logic [GROUP_SIZE-1:0] fetch_clr_w [NUM_GROUPS];

    genvar g;
    generate
        for (g = 0; g < NUM_GROUPS; g++)
        begin : gen_group
            logic [7:0] enable_r, enable_nxt;
            logic [7:0] flag_r, flag_nxt;
            logic [7:0] prev_r;
            logic [7:0] rise;
            logic wr_enable, wr_flag;

            assign wr_enable = wr_fire && aw_idx_r == IDX_GROUP_BASE + 14'(2 * g);
            assign wr_flag = wr_fire && aw_idx_r == IDX_GROUP_BASE + 14'(2 * g + 1);
            assign rise = line_w[g] & ~prev_r;

            always_comb
            begin
                enable_nxt = wr_enable ?
                             8'(pix_merge({8'h00, enable_r}, w_data_r, w_strb_r)) : enable_r;
                flag_nxt = wr_flag ? 8'(pix_merge({8'h00, flag_r}, w_data_r, w_strb_r)) :
                           (flag_r & ~fetch_clr_w[g]);
                // A line rising in the write cycle is still caught
                flag_nxt = flag_nxt | rise;
            end

            always_ff @(posedge i_clk)
            begin
                if (i_reset)
                begin
                    enable_r <= GROUP_ENABLE_RST;
                    flag_r <= GROUP_FLAG_RST;
                    prev_r <= '0;
                end
                else
                begin
                    enable_r <= enable_nxt;
                    flag_r <= flag_nxt;
                    prev_r <= line_w[g];
                end
            end

            assign flag_w[g] = flag_r;
            assign enable_w[g] = enable_r;
            assign pend_nxt_w[g] = flag_nxt & enable_nxt;
        end
    endgenerate

    // ------------------------------------------------------------
    // Control, acknowledge and vector fetch
    // ------------------------------------------------------------
    logic ctrl_en_r, ctrl_en_nxt;
    logic [14:0] ctrl_vect_r, ctrl_vect_nxt;
    logic [11:0] ack_r, ack_nxt;
    logic [11:0] irq_r, irq_nxt;
    pix_vec_rsp_t rsp_r, rsp_nxt;
    logic [3:0] req_grp;
    logic req_in_range;
    logic [7:0] req_pend;
    logic [2:0] req_pos;
    logic [7:0] vec_off;
    logic [15:0] vec_addr;
    logic [11:0] ack_wclr;

    assign req_in_range = i_vec_req.num >= 8'h01 && i_vec_req.num <= 8'h0c;
    assign req_grp = req_in_range ? 4'(i_vec_req.num - 8'h01) : 4'h0;
    assign req_pend = flag_w[req_grp] & enable_w[req_grp];
    assign req_pos = i_vec_req.fetch ? pix_lowest(req_pend) : 3'h0;
    assign vec_off = 8'(VEC_PERIPH_OFF + {req_grp, 4'h0} + {4'h0, req_pos, 1'b0});
    assign vec_addr = {2'h0, IDX_VEC_FIRST} | {8'h00, vec_off};
    assign ack_wclr = (wr_fire && aw_idx_r == IDX_ACK) ?
                      (w_data_r[11:0] & {{4{w_strb_r[1]}}, {8{w_strb_r[0]}}}) : 12'h000;

    always_comb
    begin
        for (int k = 0; k < NUM_GROUPS; k++)
        begin
            fetch_clr_w[k] = '0;
        end
        ctrl_en_nxt = ctrl_en_r;
        ctrl_vect_nxt = ctrl_vect_r;
        ack_nxt = ack_r & ~ack_wclr;
        rsp_nxt = '0;
        if (wr_fire && aw_idx_r == IDX_CTRL && w_strb_r[0])
        begin
            ctrl_en_nxt = w_data_r[CTRL_EN_BIT];
        end
        if (i_vec_req.fetch || i_vec_req.trap)
        begin
            rsp_nxt.valid = 1'b1;
            // trap zero and unknown numbers get no vector
            if (ctrl_en_r && req_in_range)
            begin
                rsp_nxt.hit = 1'b1;
                rsp_nxt.vector = {vec_mem[vec_off | 8'h01], vec_mem[vec_off]};
                ctrl_vect_nxt = vec_addr[15:1];
                if (i_vec_req.fetch)
                begin
                    if (req_pend != 8'h00)
                    begin
                        fetch_clr_w[req_grp] = 8'h01 << req_pos;
                    end
                    ack_nxt[req_grp] = 1'b1;
                end
            end
        end
        for (int k = 0; k < NUM_GROUPS; k++)
        begin
            irq_nxt[k] = ctrl_en_nxt && !ack_nxt[k] && (pend_nxt_w[k] != 8'h00);
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            ctrl_en_r <= CTRL_EN_RST;
            ctrl_vect_r <= CTRL_VECT_RST;
            ack_r <= ACK_RST;
            irq_r <= '0;
            rsp_r <= '0;
        end
        else
        begin
            ctrl_en_r <= ctrl_en_nxt;
            ctrl_vect_r <= ctrl_vect_nxt;
            ack_r <= ack_nxt;
            irq_r <= irq_nxt;
            rsp_r <= rsp_nxt;
        end
    end

    // ------------------------------------------------------------
    // Bus read channel
    // ------------------------------------------------------------
    logic arready_r, arready_nxt;
    logic rvalid_r, rvalid_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic [1:0] rresp_r, rresp_nxt;
    logic [13:0] ar_idx;
    logic [13:0] ar_grp_off;
    logic [15:0] rd_val;

    assign ar_idx = i_axi_araddr[15:2];
    assign ar_grp_off = ar_idx - IDX_GROUP_BASE;

    always_comb
    begin
        rd_val = 16'h0000;
        if (ar_idx == IDX_CTRL)
        begin
            rd_val = {ctrl_vect_r, ctrl_en_r};
        end
        else if (ar_idx == IDX_ACK)
        begin
            rd_val = {4'h0, ack_r};
        end
        else if (ar_idx >= IDX_GROUP_BASE && ar_idx <= IDX_GROUP_LAST)
        begin
            rd_val = ar_grp_off[0] ? {8'h00, flag_w[ar_grp_off[4:1]]} :
                                     {8'h00, enable_w[ar_grp_off[4:1]]};
        end
        else if (ar_idx >= IDX_VEC_FIRST && ar_idx <= IDX_VEC_LAST)
        begin
            rd_val = vec_mem[ar_idx[7:0]];
        end
    end

    always_comb
    begin
        rvalid_nxt = rvalid_r;
        rdata_nxt = rdata_r;
        rresp_nxt = rresp_r;
        if (rvalid_r && i_axi_rready)
        begin
            rvalid_nxt = 1'b0;
        end
        if (arready_r && i_axi_arvalid)
        begin
            rvalid_nxt = 1'b1;
            rdata_nxt = {16'h0000, rd_val};
            rresp_nxt = (ar_idx >= IDX_CTRL && ar_idx <= IDX_VEC_LAST) ?
                        RESP_OKAY : RESP_SLVERR;
        end
        arready_nxt = !rvalid_nxt;
    end

    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b0;
            rdata_r <= '0;
            rresp_r <= RESP_OKAY;
        end
        else
        begin
            arready_r <= arready_nxt;
            rvalid_r <= rvalid_nxt;
            rdata_r <= rdata_nxt;
            rresp_r <= rresp_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign o_cpu_irq = irq_r;
    assign o_vec_rsp = rsp_r;
    assign o_axi_awready = awready_r;
    assign o_axi_wready = wready_r;
    assign o_axi_bvalid = bvalid_r;
    assign o_axi_bresp = bresp_r;
    assign o_axi_arready = arready_r;
    assign o_axi_rvalid = rvalid_r;
    assign o_axi_rdata = rdata_r;
    assign o_axi_rresp = rresp_r;

endmodule : pix_interrupt_expander

`default_nettype wire

// ### rtl/pix_pkg.sv
// Constants, register indices and carriers of the interrupt expander.
// Assumes each 16-bit register sits in one 32-bit bus word.
package pix_pkg;

    // ------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------
    localparam int NUM_GROUPS = 12;
    localparam int GROUP_SIZE = 8;
    localparam int NUM_LINES = 96;
    localparam int VEC_WORDS = 256;

    // ------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [13:0] IDX_CTRL = 14'h0ce0;
    localparam logic [13:0] IDX_ACK = 14'h0ce1;
    localparam logic [13:0] IDX_GROUP_BASE = 14'h0ce2;
    localparam logic [13:0] IDX_GROUP_LAST = 14'h0cf9;
    localparam logic [13:0] IDX_RSVD_LAST = 14'h0cff;
    localparam logic [13:0] IDX_VEC_FIRST = 14'h0d00;
    localparam logic [13:0] IDX_VEC_LAST = 14'h0dff;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int CTRL_EN_BIT = 0;
    localparam logic CTRL_EN_RST = 1'b0;
    localparam logic [14:0] CTRL_VECT_RST = 15'h0000;
    localparam logic [11:0] ACK_RST = 12'h000;
    localparam logic [7:0] GROUP_ENABLE_RST = 8'h00;
    localparam logic [7:0] GROUP_FLAG_RST = 8'h00;

    // Word of member 1.1; groups step 16, members 2
    localparam logic [7:0] VEC_PERIPH_OFF = 8'h40;

    // ------------------------------------------------------------
    // Bus answers
    // ------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic low_power_wake_irq;
        logic timer_zero_irq;
        logic converter_irq;
        logic ext_irq_two;
        logic ext_irq_one;
        logic sequencer_two_irq;
        logic sequencer_one_irq;
        logic [15:0] pwm_trip_irq;
        logic [15:0] pwm_event_irq;
        logic serial_port_rx_irq;
        logic serial_port_tx_irq;
        logic two_wire_irq_one;
        logic two_wire_irq_two;
        logic uart_rx_irq;
        logic uart_tx_irq;
    } pix_periph_irq_t;

    typedef struct packed {
        logic fetch;
        logic trap;
        logic [7:0] num;
    } pix_vec_req_t;

    typedef struct packed {
        logic valid;
        logic hit;
        logic [31:0] vector;
    } pix_vec_rsp_t;

endpackage : pix_pkg

// ### tb/pix_exp_monitor.sv
// Checker on the expander's ports.
// Assumes i_clk and synchronous active-high i_reset.
`timescale 1ns/100ps
`default_nettype none
module pix_exp_monitor (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire pix_pkg::pix_periph_irq_t i_periph,
    input wire pix_pkg::pix_vec_req_t i_vec_req,
    input wire logic [11:0] o_cpu_irq,
    input wire pix_pkg::pix_vec_rsp_t o_vec_rsp,
    input wire logic [15:0] i_axi_araddr,
    input wire logic i_axi_arvalid,
    input wire logic o_axi_arready,
    input wire logic [31:0] o_axi_rdata,
    input wire logic [1:0] o_axi_rresp,
    input wire logic o_axi_rvalid,
    input wire logic i_axi_rready,
    input wire logic [1:0] o_axi_bresp,
    input wire logic o_axi_bvalid,
    input wire logic i_axi_bready
);
import pix_pkg::*;
default clocking cb @(posedge i_clk); endclocking
default disable iff (i_reset);
logic req;
logic [11:0] fmask;
assign req = i_vec_req.fetch | i_vec_req.trap;
always_comb fmask = (i_vec_req.fetch && i_vec_req.num inside {[8'h01:8'h0c]})
    ? 12'h001 << (i_vec_req.num - 8'h01) : 12'h000;
// ------------------------------------------------------------
// Vector port
// ------------------------------------------------------------
chk_rsp_follows: assert property (req |=> o_vec_rsp.valid)
    else $error("no vector answer");
chk_rsp_cause: assert property (o_vec_rsp.valid |-> $past(req))
    else $error("stray vector answer");
chk_num_refused: assert property (req && !(i_vec_req.num inside {[8'h01:8'h0c]})
    |=> !o_vec_rsp.hit && o_vec_rsp.vector == 32'h0)
    else $error("bad number served");
chk_fetch_holds: assert property (fmask != 12'h000 |=> (o_cpu_irq & $past(fmask)) == 12'h000)
    else $error("request up after fetch");
chk_irq_cause: assert property ($changed(o_cpu_irq) |-> $rose(o_axi_bvalid)
    || $past(i_vec_req.fetch) || ($past(i_periph) & ~$past(i_periph, 2)) != '0)
    else $error("request moved uncaused");
// ------------------------------------------------------------
// Register bus
// ------------------------------------------------------------
chk_bresp_hold: assert property (o_axi_bvalid && !i_axi_bready
    |=> o_axi_bvalid && $stable(o_axi_bresp))
    else $error("bvalid dropped");
chk_rdata_hold: assert property (o_axi_rvalid && !i_axi_rready
    |=> o_axi_rvalid && $stable(o_axi_rdata))
    else $error("rvalid dropped");
chk_bad_addr: assert property (i_axi_arvalid && o_axi_arready
    && (i_axi_araddr < 16'h3380 || i_axi_araddr > 16'h37fc)
    |=> o_axi_rvalid && o_axi_rresp == RESP_SLVERR && o_axi_rdata == 32'h0)
    else $error("bad read accepted");
chk_ar_refused: assert property (o_axi_rvalid |-> !o_axi_arready)
    else $error("arready while rvalid");
endmodule : pix_exp_monitor

bind pix_interrupt_expander pix_exp_monitor i_mon (.i_clk, .i_reset, .i_periph, .i_vec_req,
    .o_cpu_irq, .o_vec_rsp, .i_axi_araddr, .i_axi_arvalid, .o_axi_arready, .o_axi_rdata,
    .o_axi_rresp, .o_axi_rvalid, .i_axi_rready, .o_axi_bresp, .o_axi_bvalid, .i_axi_bready);
`default_nettype wire

// ### tb/pix_cpu_model.sv
// CPU model: takes group interrupts, issues traps.
// Assumes every vector request is answered.
`timescale 1ns/100ps
`default_nettype none
module pix_cpu_model (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic [11:0] i_cpu_irq,
    input wire pix_pkg::pix_vec_rsp_t i_vec_rsp,
    input wire logic i_go,
    input wire logic i_trap,
    input wire logic [7:0] i_num,
    input wire logic [3:0] i_delay,
    output pix_pkg::pix_vec_req_t o_vec_req,
    output logic o_busy,
    output pix_pkg::pix_vec_rsp_t o_rsp
);
import pix_pkg::*;
pix_vec_req_t req_r = '0;
pix_vec_rsp_t rsp_r = '0;
logic busy_r = 1'b0;
logic sent_r = 1'b0;
logic trap_r = 1'b0;
logic [7:0] num_r = '0;
logic [3:0] cnt_r = '0;
assign o_vec_req = req_r;
assign o_busy = busy_r;
assign o_rsp = rsp_r;

// Lowest CPU input wins
function automatic logic [7:0] first_grp(input logic [11:0] v);
    first_grp = 8'h01;
    for (int k = 11; k >= 0; k--)
        if (v[k])
            first_grp = 8'(k + 1);
endfunction : first_grp

always @(posedge i_clk)
begin
    req_r <= '0;
    if (i_reset)
    begin
        busy_r <= 1'b0;
        sent_r <= 1'b0;
    end
    else if (i_go && !busy_r && !(i_trap && i_num == 8'h00))
    begin
        busy_r <= 1'b1;
        trap_r <= i_trap;
        num_r <= i_num;
        cnt_r <= i_delay;
    end
    else if (busy_r && !sent_r && cnt_r != 4'h0)
        cnt_r <= cnt_r - 4'h1;
    else if (busy_r && !sent_r)
    begin
        req_r.fetch <= !trap_r;
        req_r.trap <= trap_r;
        req_r.num <= trap_r ? num_r : first_grp(i_cpu_irq);
        sent_r <= 1'b1;
    end
    else if (sent_r && i_vec_rsp.valid)
    begin
        rsp_r <= i_vec_rsp;
        busy_r <= 1'b0;
        sent_r <= 1'b0;
    end
end
endmodule : pix_cpu_model
`default_nettype wire

// ### tb/tb_top.sv
// Testbench: bus tasks, line map, traps, fetches.
// Assumes the CPU model on the vector port, checker bound.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
import pix_pkg::*;
logic i_clk = 1'b0;
logic i_reset = 1'b1;
logic i_protected_write_unlock = 1'b0;
pix_periph_irq_t i_periph = '0;
pix_vec_req_t i_vec_req;
pix_vec_rsp_t o_vec_rsp, rsp;
logic [11:0] o_cpu_irq;
logic [15:0] i_axi_awaddr = '0, i_axi_araddr = '0;
logic [31:0] i_axi_wdata = '0;
logic [3:0] i_axi_wstrb = 4'h3;
logic i_axi_awvalid = 1'b0, i_axi_wvalid = 1'b0, i_axi_bready = 1'b0;
logic i_axi_arvalid = 1'b0, i_axi_rready = 1'b0;
logic o_axi_awready, o_axi_wready, o_axi_bvalid, o_axi_arready, o_axi_rvalid;
logic [1:0] o_axi_bresp, o_axi_rresp, r;
logic [31:0] o_axi_rdata;
logic go = 1'b0, trp = 1'b0, busy;
logic [7:0] num = '0, m;
logic [3:0] dly = '0;
logic [15:0] d;
int n_fail = 0, cmp_count = 0;

always #50 i_clk = ~i_clk;

pix_interrupt_expander i_pix_interrupt_expander (.i_clk, .i_reset, .i_periph,
    .i_protected_write_unlock, .i_vec_req, .o_cpu_irq, .o_vec_rsp, .i_axi_awaddr,
    .i_axi_awvalid, .o_axi_awready, .i_axi_wdata, .i_axi_wstrb, .i_axi_wvalid, .o_axi_wready,
    .o_axi_bresp, .o_axi_bvalid, .i_axi_bready, .i_axi_araddr, .i_axi_arvalid, .o_axi_arready,
    .o_axi_rdata, .o_axi_rresp, .o_axi_rvalid, .i_axi_rready);
pix_cpu_model i_pix_cpu_model (.i_clk, .i_reset, .i_cpu_irq(o_cpu_irq), .i_vec_rsp(o_vec_rsp),
    .i_go(go), .i_trap(trp), .i_num(num), .i_delay(dly), .o_vec_req(i_vec_req),
    .o_busy(busy), .o_rsp(rsp));

// ------------------------------------------------------------
// Helpers
// ------------------------------------------------------------
task automatic report_and_stop;
    $display("checks %0d fails %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
        $display("Run complete: PASS");
    else
        $display("Run complete: FAIL");
    $finish;
endtask : report_and_stop

task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
        n_fail++;
        $display("wrong value %s expected %h seen %h", nm, e, g);
    end
endtask : chk

task automatic limit(input logic ok);
    if (!ok)
    begin
        n_fail++;
        report_and_stop();
    end
endtask : limit

task automatic wr(input logic [15:0] a, input logic [15:0] v);
    int n = 0;
    logic done = 1'b0;
    @(posedge i_clk);
    i_axi_awaddr <= a;
    i_axi_wdata <= {16'h0000, v};
    i_axi_awvalid <= 1'b1;
    i_axi_wvalid <= 1'b1;
    i_axi_bready <= 1'b1;
    while (!done && n < 50)
    begin
        @(posedge i_clk);
        n++;
        if (o_axi_awready)
            i_axi_awvalid <= 1'b0;
        if (o_axi_wready)
            i_axi_wvalid <= 1'b0;
        done = o_axi_bvalid;
    end
    i_axi_bready <= 1'b0;
    limit(done);
    chk("bresp", 32'(RESP_OKAY), 32'(o_axi_bresp));
endtask : wr

task automatic rd(input logic [15:0] a, output logic [15:0] v, output logic [1:0] rs);
    int n = 0;
    logic done = 1'b0;
    @(posedge i_clk);
    i_axi_araddr <= a;
    i_axi_arvalid <= 1'b1;
    i_axi_rready <= 1'b1;
    while (!done && n < 50)
    begin
        @(posedge i_clk);
        n++;
        if (o_axi_arready)
            i_axi_arvalid <= 1'b0;
        done = o_axi_rvalid;
    end
    i_axi_rready <= 1'b0;
    v = o_axi_rdata[15:0];
    rs = o_axi_rresp;
    limit(done);
endtask : rd

task automatic rc(input logic [15:0] a, input logic [15:0] e);
    rd(a, d, r);
    chk($sformatf("reg %h", a), 32'(e), 32'(d));
endtask : rc

task automatic vx(input logic t, input logic [7:0] k, input logic [3:0] w);
    int n = 0;
    @(posedge i_clk);
    go <= 1'b1;
    trp <= t;
    num <= k;
    dly <= w;
    @(posedge i_clk);
    go <= 1'b0;
    @(posedge i_clk);
    while (busy && n < 50)
    begin
        @(posedge i_clk);
        n++;
    end
    limit(!busy);
endtask : vx

// Word k holds 0x1000 + k
function automatic logic [31:0] vexp(input int g, input int p);
    logic [15:0] w;
    w = 16'h1040 + 16'((g - 1) * 16 + (p - 1) * 2);
    return {w + 16'h0001, w};
endfunction : vexp

task automatic vchk(input logic h, input int g, input int p);
    chk("hit", 32'(h), 32'(rsp.hit));
    chk("vector", h ? vexp(g, p) : 32'h0, rsp.vector);
endtask : vchk

// f: 0 enable, 1 flag
function automatic logic [15:0] ga(input int g, input int f);
    return {IDX_GROUP_BASE + 14'((g - 1) * 2 + f), 2'b00};
endfunction : ga

// Bit to {group, member}
function automatic logic [7:0] lmap(input int b);
    if (b >= 38)
        return (b == 38) ? 8'h11 : (b == 39) ? 8'h12 : {4'h1, 4'(b - 36)};
    if (b >= 22)
        return (b < 30) ? {4'h2, 4'(b - 21)} : {4'ha, 4'(b - 29)};
    if (b >= 6)
        return (b < 14) ? {4'h3, 4'(b - 5)} : {4'hb, 4'(b - 13)};
    return (b >= 4) ? {4'h6, 4'(6 - b)} : (b >= 2) ? {4'h8, 4'(4 - b)} : {4'h9, 4'(2 - b)};
endfunction : lmap

// ------------------------------------------------------------
// Sequence
// ------------------------------------------------------------
initial
begin
    repeat (8) @(posedge i_clk);
    i_reset <= 1'b0;
    rc({IDX_CTRL, 2'b00}, 16'h0000);
    rc({IDX_ACK, 2'b00}, 16'h0000);
    for (int g = 1; g <= 12; g++)
    begin
        rc(ga(g, 0), 16'h0000);
        rc(ga(g, 1), 16'h0000);
    end
    rc(16'h33e8, 16'h0000);
    rd(16'h3000, d, r);
    chk("rresp", 32'(RESP_SLVERR), 32'(r));
    i_protected_write_unlock <= 1'b1;
    for (int k = 0; k < 256; k++)
        wr(16'h3400 + 16'(4 * k), 16'h1000 + 16'(k));
    i_protected_write_unlock <= 1'b0;
    wr(16'h3500, 16'hdead);
    rc(16'h3500, 16'h1040);
    vx(1'b1, 8'h01, 4'h0);
    vchk(1'b0, 1, 1);
    wr({IDX_CTRL, 2'b00}, 16'h0001);
    for (int t = 1; t <= 13; t++)
    begin
        vx(1'b1, 8'(t), 4'h0);
        vchk(t < 13, t, 1);
    end
    for (int g = 1; g <= 12; g++)
        wr(ga(g, 0), 16'h00ff);
    for (int b = 0; b < 45; b++)
    begin
        m = lmap(b);
        i_periph <= pix_periph_irq_t'(45'h1 << b);
        @(posedge i_clk);
        i_periph <= '0;
        @(posedge i_clk);
        chk("cpu_irq", 32'(12'h001 << (m[7:4] - 1)), 32'(o_cpu_irq));
        rc(ga(m[7:4], 1), 16'h0001 << (m[3:0] - 1));
        wr(ga(m[7:4], 1), 16'h0000);
    end
    i_periph <= pix_periph_irq_t'(45'h1 << 40);
    @(posedge i_clk);
    i_periph <= '0;
    wr(ga(1, 1), 16'h0001);
    rc(ga(1, 1), 16'h0001);
    wr(ga(1, 1), 16'h0000);
    wr(ga(4, 0), 16'h000c);
    wr(ga(4, 1), 16'h000e);
    chk("cpu_irq", 32'h008, 32'(o_cpu_irq));
    vx(1'b0, 8'h04, 4'h0);
    vchk(1'b1, 4, 3);
    chk("cpu_irq", 32'h000, 32'(o_cpu_irq));
    rc({IDX_ACK, 2'b00}, 16'h0008);
    rc(ga(4, 1), 16'h000a);
    wr({IDX_ACK, 2'b00}, 16'h0008);
    chk("cpu_irq", 32'h008, 32'(o_cpu_irq));
    vx(1'b0, 8'h04, 4'h5);
    vchk(1'b1, 4, 4);
    rc(ga(4, 1), 16'h0002);
    report_and_stop();
end
endmodule : tb_top
`default_nettype wire
